//--- verilog/supervisor_pkg.sv
/*
  Constants shared by the supervisory reset and status logic: register
  offsets, field positions, reset values and timing counts.
  Assumes a 125 MHz system clock; no other files are needed.
*/
package supervisor_pkg;

  // --------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RST_QUAL_NS = 100;
  // Least time: rounded up to whole cycles.
  localparam int RST_QUAL_CYC = (RST_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_LONG_MS = 97;
  localparam int REC_STOP_MS = 100;
  localparam int REC_SHORT_US = 1000;
  localparam int REC_LONG_CYC = REC_LONG_MS * 125000;
  localparam int REC_STOP_CYC = REC_STOP_MS * 125000;
  localparam int REC_SHORT_CYC = REC_SHORT_US * 125;
  localparam int BATT_CHECK_HOURS = 24;
  localparam longint BATT_CHECK_CYC = 64'(BATT_CHECK_HOURS) * 3600 * 125000000;
  localparam int OSC_RUN_SEC = 4;

  // --------------------------------------------------------------------
  // Register map (word index on the plain register port)
  // --------------------------------------------------------------------
  localparam logic [3:0] ADDR_CLOCK = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_FLAGS = 4'hF;
  localparam logic [3:0] ADDR_CENTURY = 4'h1;
  localparam logic [3:0] ADDR_SERIAL = 4'h2;
  localparam logic [3:0] ADDR_SERIAL_SEL = 4'h3;

  // Field positions.
  localparam int CLK_REC_SEL_BIT = 7;
  localparam int CLK_OSC_STOP_BIT = 6;
  localparam int CTRL_OUT_BIT = 7;
  localparam int CTRL_OSC_IRQ_EN_BIT = 0;
  localparam int CTRL_BACKUP_ALARM_BIT = 1;
  localparam int CTRL_ALARM_EN_BIT = 2;
  localparam int CTRL_TAMPER_EN_BIT = 3;
  localparam int CTRL_WDIRQ_BIT = 4;
  localparam int CTRL_OPEN_DRAIN_BIT = 5;
  localparam int FLAG_OSC_FAIL_BIT = 2;
  localparam int FLAG_BATT_LOW_BIT = 4;

  // Values after initial power-up: output level bit and open-drain select set.
  localparam logic [7:0] CTRL_RESET = 8'hA0;
  localparam logic [7:0] CLOCK_RESET = 8'h00;

  // Serial number: arbitrary neutral value, not tied to any part.
  localparam logic [63:0] SERIAL_DEFAULT = 64'h0123_4567_89AB_CD00;

endpackage

//--- verilog/supervisor_reset_status_logic.sv
/*
  Supervisory reset, power-fail gating, interrupt pin and status flags of
  a serial clock device. Assumes all inputs but reset_i and the synchronised external reset inputs are synchronous to clk_sys_i,
  that analog comparators and the battery measurement arrive as logic
  levels, and that the oscillator running status arrives from outside as a logic level.
*/
`timescale 1ns/100ps
module supervisor_reset_status_logic #(
  parameter int QUAL_CYC = supervisor_pkg::RST_QUAL_CYC,
  parameter int REC_LONG = supervisor_pkg::REC_LONG_CYC,
  parameter int REC_STOP = supervisor_pkg::REC_STOP_CYC,
  parameter int REC_SHORT = supervisor_pkg::REC_SHORT_CYC,
  parameter longint BATT_PERIOD = supervisor_pkg::BATT_CHECK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ext_reset_in_a_n_i,
  input wire logic ext_reset_in_b_n_i,
  input wire logic supply_good_i,
  input wire logic supply_sense_in_a_low_i,
  input wire logic supply_sense_in_b_low_i,
  input wire logic osc_running_i,
  input wire logic battery_low_i,
  input wire logic century_rollover_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  output logic system_reset_n_o,
  output logic supply_fail_out_a_o,
  output logic supply_fail_out_a_oe_o,
  output logic supply_fail_out_b_o,
  output logic supply_fail_out_b_oe_o,
  output logic irq_out_o,
  output logic irq_out_oe_o,
  output logic leap_century_o
);

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  // The qualification counter is eight bits wide, so longer filters cannot be served.
  if (QUAL_CYC < 1 || QUAL_CYC > 255 || REC_SHORT < 1 || REC_LONG < 1 || REC_STOP < 1
      || BATT_PERIOD < 1) begin : g_bad_count
    $error("supervisor: counts out of range for the counters");
  end

  // --------------------------------------------------------------------
  // Reset input synchronisers and qualification filters
  // --------------------------------------------------------------------
  logic [1:0] sync_a_reg;
  logic [1:0] sync_b_reg;
  logic [7:0] qual_a_reg;
  logic [7:0] qual_b_reg;
  logic [7:0] qual_a_next;
  logic [7:0] qual_b_next;
  wire qual_a_done = (qual_a_reg >= 8'(QUAL_CYC));
  wire qual_b_done = (qual_b_reg >= 8'(QUAL_CYC));
  wire ext_hold = qual_a_done || qual_b_done;

  // A low must persist every cycle; any high restarts the count, so a
  // glitch shorter than the qualifying width never reaches the output.
  assign qual_a_next = sync_a_reg[1] ? 8'h00 : (qual_a_done ? qual_a_reg : qual_a_reg + 8'h01);
  assign qual_b_next = sync_b_reg[1] ? 8'h00 : (qual_b_done ? qual_b_reg : qual_b_reg + 8'h01);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a_reg <= 2'b11;
      sync_b_reg <= 2'b11;
      qual_a_reg <= 8'h00;
      qual_b_reg <= 8'h00;
    end else begin
      sync_a_reg <= {sync_a_reg[0], ext_reset_in_a_n_i};
      sync_b_reg <= {sync_b_reg[0], ext_reset_in_b_n_i};
      qual_a_reg <= qual_a_next;
      qual_b_reg <= qual_b_next;
    end
  end

  // --------------------------------------------------------------------
  // Recovery delay counter
  // --------------------------------------------------------------------
  typedef enum {STATE_RUN, STATE_HOLD, STATE_RECOVER} sup_state_type;
  sup_state_type state_reg;
  sup_state_type state_next;
  logic [31:0] rec_cnt_reg;
  logic [31:0] rec_cnt_next;
  logic rec_select_reg;
  logic osc_stop_reg;
  wire reset_cause = ext_hold || !supply_good_i;
  // Terminal count chosen from select and stop bits as the cause goes away.
  wire [31:0] rec_load = rec_select_reg ? 32'(REC_SHORT) :
                         (osc_stop_reg ? 32'(REC_STOP) : 32'(REC_LONG));

  always_comb begin
    state_next = state_reg;
    rec_cnt_next = rec_cnt_reg;
    case (state_reg)
      STATE_RUN: begin
        if (reset_cause) begin
          state_next = STATE_HOLD;
        end
      end
      STATE_HOLD: begin
        if (!reset_cause) begin
          state_next = STATE_RECOVER;
          rec_cnt_next = rec_load - 32'd1;
        end
      end
      STATE_RECOVER: begin
        if (reset_cause) begin
          state_next = STATE_HOLD;
        end else if (rec_cnt_reg == 32'd0) begin
          state_next = STATE_RUN;
        end else begin
          rec_cnt_next = rec_cnt_reg - 32'd1;
        end
      end
      default: state_next = STATE_HOLD;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= STATE_HOLD;
      rec_cnt_reg <= 32'd0;
    end else begin
      state_reg <= state_next;
      rec_cnt_reg <= rec_cnt_next;
    end
  end

  wire in_reset = (state_reg != STATE_RUN);
  wire on_battery = !supply_good_i;
  // Internal reset that clears the control enable bits on main supply; OUT and open-drain select keep their values.
  wire sys_rst_pulse = in_reset;
  assign system_reset_n_o = !in_reset;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  wire wr_clock = reg_write_i && (reg_addr_i == supervisor_pkg::ADDR_CLOCK);
  wire wr_ctrl = reg_write_i && (reg_addr_i == supervisor_pkg::ADDR_CTRL);
  wire wr_flags = reg_write_i && (reg_addr_i == supervisor_pkg::ADDR_FLAGS);
  wire wr_sel = reg_write_i && (reg_addr_i == supervisor_pkg::ADDR_SERIAL_SEL);
  logic [7:0] ctrl_reg;
  logic [2:0] serial_sel_reg;
  logic osc_fail_reg;
  logic batt_low_reg;
  logic [1:0] century_reg;

  // Clock register holds the recovery select and stop bits; stored in
  // backed-up state, so a supervisory reset leaves them unchanged.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rec_select_reg <= 1'b0;
      osc_stop_reg <= 1'b0;
    end else if (wr_clock && !in_reset) begin
      rec_select_reg <= reg_wdata_i[supervisor_pkg::CLK_REC_SEL_BIT];
      osc_stop_reg <= reg_wdata_i[supervisor_pkg::CLK_OSC_STOP_BIT];
    end
  end

  // Interrupt-source enables clear on every reset except a supervisory reset on battery; OUT and open-drain
  // select survive a supervisory reset as backed-up bits.
  wire [7:0] enable_mask = 8'h1F;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= supervisor_pkg::CTRL_RESET;
    end else if (sys_rst_pulse) begin
      // On battery the enables are kept so the backup enable can act; they clear at power-up.
      if (supply_good_i) begin
        ctrl_reg <= ctrl_reg & ~enable_mask;
      end
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata_i;
    end
  end

  // --------------------------------------------------------------------
  // Oscillator fail flag: set wins over a software clear.
  // --------------------------------------------------------------------
  wire osc_stopped = !osc_running_i || osc_stop_reg;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      osc_fail_reg <= 1'b1;
    end else if (osc_stopped) begin
      osc_fail_reg <= 1'b1;
    end else if (wr_flags && !reg_wdata_i[supervisor_pkg::FLAG_OSC_FAIL_BIT]) begin
      osc_fail_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Battery check scheduler, run only on main supply.
  // --------------------------------------------------------------------
  logic [63:0] batt_cnt_reg;
  logic powered_reg;
  wire batt_due = !on_battery && (!powered_reg || batt_cnt_reg == 64'd0);
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      batt_cnt_reg <= 64'd0;
      powered_reg <= 1'b0;
      batt_low_reg <= 1'b0;
    end else begin
      powered_reg <= !on_battery;
      if (batt_due) begin
        batt_cnt_reg <= 64'(BATT_PERIOD - 1);
        batt_low_reg <= battery_low_i;
      end else if (!on_battery) begin
        batt_cnt_reg <= batt_cnt_reg - 64'd1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Century bits and serial number window.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      century_reg <= 2'b00;
      serial_sel_reg <= 3'd0;
    end else begin
      if (century_rollover_i) begin
        century_reg <= century_reg + 2'b01;
      end
      if (wr_sel) begin
        serial_sel_reg <= reg_wdata_i[2:0];
      end
    end
  end
  assign leap_century_o = (century_reg == 2'b00);
  wire [7:0] serial_byte = supervisor_pkg::SERIAL_DEFAULT[{serial_sel_reg, 3'b000} +: 8];

  // --------------------------------------------------------------------
  // Read data, valid in the cycle after the read strobe.
  // --------------------------------------------------------------------
  wire [7:0] flags_val = {3'b000, batt_low_reg, 1'b0, osc_fail_reg, 2'b00};
  wire [7:0] clock_val = {rec_select_reg, osc_stop_reg, 6'b000000};
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      supervisor_pkg::ADDR_CLOCK: rd_mux = clock_val;
      supervisor_pkg::ADDR_CTRL: rd_mux = ctrl_reg;
      supervisor_pkg::ADDR_FLAGS: rd_mux = flags_val;
      supervisor_pkg::ADDR_CENTURY: rd_mux = {6'b000000, century_reg};
      supervisor_pkg::ADDR_SERIAL: rd_mux = serial_byte;
      supervisor_pkg::ADDR_SERIAL_SEL: rd_mux = {5'b00000, serial_sel_reg};
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_read_i ? rd_mux : 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Power-fail outputs: low on battery, high during recovery, then follow.
  // --------------------------------------------------------------------
  wire pf_od = ctrl_reg[supervisor_pkg::CTRL_OPEN_DRAIN_BIT];
  wire pf_a = on_battery ? 1'b0 : (in_reset ? 1'b1 : !supply_sense_in_a_low_i);
  wire pf_b = on_battery ? 1'b0 : (in_reset ? 1'b1 : !supply_sense_in_b_low_i);
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      supply_fail_out_a_o <= 1'b0;
      supply_fail_out_b_o <= 1'b0;
    end else begin
      supply_fail_out_a_o <= pf_a;
      supply_fail_out_b_o <= pf_b;
    end
  end
  // Open drain only drives the low level; push-pull drives both.
  assign supply_fail_out_a_oe_o = !pf_od || !supply_fail_out_a_o;
  assign supply_fail_out_b_oe_o = !pf_od || !supply_fail_out_b_o;

  // --------------------------------------------------------------------
  // Interrupt / output pin (open drain, active low).
  // --------------------------------------------------------------------
  wire osc_irq_en = ctrl_reg[supervisor_pkg::CTRL_OSC_IRQ_EN_BIT];
  wire backup_alarm_en = ctrl_reg[supervisor_pkg::CTRL_BACKUP_ALARM_BIT];
  wire any_src = osc_irq_en || ctrl_reg[supervisor_pkg::CTRL_ALARM_EN_BIT] ||
                 ctrl_reg[supervisor_pkg::CTRL_TAMPER_EN_BIT] ||
                 ctrl_reg[supervisor_pkg::CTRL_WDIRQ_BIT];
  wire pin_ok = !on_battery || backup_alarm_en;
  // The supply-loss reset must not mask the pin on battery; the backup enable gates it there.
  wire osc_irq = osc_irq_en && osc_fail_reg && (!in_reset || on_battery) && pin_ok;
  wire out_low = !any_src && !ctrl_reg[supervisor_pkg::CTRL_OUT_BIT] && pin_ok;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_out_oe_o <= 1'b0;
    end else begin
      irq_out_oe_o <= osc_irq || out_low;
    end
  end
  assign irq_out_o = 1'b0;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_glitch_ignored: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_reg == STATE_RUN && supply_good_i && $rose(sync_a_reg[1]) && qual_a_reg < 8'(QUAL_CYC)
     && !qual_b_done) |=> state_reg == STATE_RUN)
    else $error("short reset pulse caused a reset");
  a_reset_follows: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ext_hold |=> !system_reset_n_o)
    else $error("qualified reset input did not assert reset");
  a_recovery_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_reg == STATE_RECOVER && rec_cnt_reg != 32'd0 && !reset_cause) |=> !system_reset_n_o)
    else $error("reset released before delay end");
  a_pf_forced_high: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (in_reset && supply_good_i) |=> supply_fail_out_a_o && supply_fail_out_b_o)
    else $error("fail outputs not forced high during recovery");
  a_pf_battery_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    on_battery |=> !supply_fail_out_a_o && !supply_fail_out_b_o)
    else $error("fail outputs not low on battery");
  a_of_sticky: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (osc_fail_reg && !(wr_flags && !reg_wdata_i[supervisor_pkg::FLAG_OSC_FAIL_BIT]))
    |=> osc_fail_reg)
    else $error("oscillator fail flag lost");
  a_enables_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (in_reset && supply_good_i) |=> (ctrl_reg[4:0] == 5'b00000))
    else $error("enables survive reset");
  a_osc_irq_pin: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (osc_irq_en && osc_fail_reg && !in_reset && supply_good_i) |=> irq_out_oe_o)
    else $error("oscillator interrupt not driven");
  a_century_leap: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    century_rollover_i |=> century_reg == $past(century_reg) + 2'b01)
    else $error("century count wrong");
  a_fail_follow: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!on_battery && !in_reset) |=> (supply_fail_out_a_o == !$past(supply_sense_in_a_low_i)
     && supply_fail_out_b_o == !$past(supply_sense_in_b_low_i)))
    else $error("fail outputs do not follow sense inputs");
  a_backup_pin: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (on_battery && backup_alarm_en && !any_src && !ctrl_reg[supervisor_pkg::CTRL_OUT_BIT])
    |=> irq_out_oe_o)
    else $error("output pin not driven low on battery");
  a_batt_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !batt_due |=> batt_low_reg == $past(batt_low_reg))
    else $error("battery low flag changed without a check");
  a_osc_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    osc_stopped |=> osc_fail_reg)
    else $error("oscillator fail flag not set");

endmodule

//--- testbench/host_reset_model.sv
/*
  Host reset model: pulls one external reset input low for a given
  number of cycles. Assumes the bench starts one pulse at a time.
*/
`timescale 1ns/100ps
module host_reset_model (
  input wire logic clk_sys_i,
  input wire logic start_a_i,
  input wire logic start_b_i,
  input wire logic [7:0] width_i,
  output logic reset_a_n_o,
  output logic reset_b_n_o
);
  // ------------------------------------------------------------------
  // Pulse timer
  // ------------------------------------------------------------------
  logic [7:0] left_reg = 8'h00;
  logic on_b_reg = 1'b0;

  // The width is taken as given, so the bench can also send short glitches.
  always_ff @(posedge clk_sys_i) begin
    if (start_a_i || start_b_i) begin
      left_reg <= width_i;
      on_b_reg <= start_b_i;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end

  // The inputs have pull-ups, so a released line reads high.
  assign reset_a_n_o = !(left_reg != 8'h00 && !on_b_reg);
  assign reset_b_n_o = !(left_reg != 8'h00 && on_b_reg);
endmodule

//--- testbench/tb_supervisor_reset_status_logic.sv
/*
  Self-checking bench for the supervisory reset and status logic.
  Assumes the design package and the host reset model are compiled first.
*/
`timescale 1ns/100ps
module tb_supervisor_reset_status_logic;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  localparam int REC_L = 20;
  localparam int REC_T = 30;
  localparam int REC_S = 10;
  localparam int BATT = 50;
  logic clk_sys_i, reset_i, supply_good, sense_a, sense_b, osc_run, batt_low, roll;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, width;
  logic wr_s, rd_s, start_a, start_b, rst_a_n, rst_b_n;
  logic sys_rst_n, fa, fa_oe, fb, fb_oe, irq, irq_oe, leap;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  supervisor_reset_status_logic #(.REC_LONG(REC_L), .REC_STOP(REC_T), .REC_SHORT(REC_S),
      .BATT_PERIOD(BATT)) supervisor_reset_status_logic_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ext_reset_in_a_n_i(rst_a_n),
    .ext_reset_in_b_n_i(rst_b_n), .supply_good_i(supply_good),
    .supply_sense_in_a_low_i(sense_a), .supply_sense_in_b_low_i(sense_b),
    .osc_running_i(osc_run), .battery_low_i(batt_low), .century_rollover_i(roll),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .system_reset_n_o(sys_rst_n), .supply_fail_out_a_o(fa),
    .supply_fail_out_a_oe_o(fa_oe), .supply_fail_out_b_o(fb), .supply_fail_out_b_oe_o(fb_oe),
    .irq_out_o(irq), .irq_out_oe_o(irq_oe), .leap_century_o(leap));

  host_reset_model host_reset_model_i (.clk_sys_i(clk_sys_i), .start_a_i(start_a),
    .start_b_i(start_b), .width_i(width), .reset_a_n_o(rst_a_n), .reset_b_n_o(rst_b_n));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Level of an open-drain or push-pull pin with its pull-up.
  function automatic logic pin(input logic o, input logic oe);
    return oe ? o : 1'b1;
  endfunction

  // Steps past the edge so registered outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_in(input string what, input int v, input int lo, input int hi);
    check_count++;
    if (v < lo || v > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, v);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  task automatic irq_is(input string what, input logic exp);
    tick(2);
    chk(what, exp, irq_oe);
    chk("irq_pin_level", !exp, pin(irq, irq_oe));
  endtask

  task automatic pulse(input logic b, input logic [7:0] w);
    @(posedge clk_sys_i);
    start_a <= !b;
    start_b <= b;
    width <= w;
    @(posedge clk_sys_i);
    start_a <= 1'b0;
    start_b <= 1'b0;
    #1;
  endtask

  // One 30-cycle reset pulse, timing both the assert and the release.
  task automatic hit(input logic b, input int rec);
    int n;
    n = 0;
    pulse(b, 8'h1E);
    while (sys_rst_n !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    chk_in("reset_assert", n, 12, 25);
    while (sys_rst_n !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    chk_in("reset_release", n, 30 + rec, 38 + rec);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_in;
    int n;
    pulse(1'b0, 8'h08);
    for (n = 0; n < 40; n++) begin
      tick(1);
      chk("short_pulse", 8'h01, sys_rst_n);
    end
    hit(1'b0, REC_L);
    wr(supervisor_pkg::ADDR_CTRL, 8'h9F);
    hit(1'b1, REC_L);
    rd("ctrl_cleared", supervisor_pkg::ADDR_CTRL, 8'h80);
    wr(supervisor_pkg::ADDR_CLOCK, 8'h80);
    rd("clock_tr", supervisor_pkg::ADDR_CLOCK, 8'h80);
    hit(1'b1, REC_S);
    wr(supervisor_pkg::ADDR_CLOCK, 8'h40);
    hit(1'b0, REC_T);
    wr(supervisor_pkg::ADDR_CLOCK, 8'h00);
  endtask

  task automatic t_fail_out;
    int n;
    @(posedge clk_sys_i);
    sense_a <= 1'b1;
    tick(3);
    chk("fail_a_push", 8'h02, {fa_oe, pin(fa, fa_oe)});
    chk("fail_b_push", 8'h03, {fb_oe, pin(fb, fb_oe)});
    wr(supervisor_pkg::ADDR_CTRL, 8'h22);
    irq_is("irq_out_low", 1'b1);
    chk("fail_a_open", 8'h02, {fa_oe, pin(fa, fa_oe)});
    chk("fail_b_open", 8'h01, {fb_oe, pin(fb, fb_oe)});
    @(posedge clk_sys_i);
    supply_good <= 1'b0;
    batt_low <= 1'b1;
    tick(4);
    chk("fail_backup", 8'h00, {pin(fa, fa_oe), pin(fb, fb_oe)});
    chk("irq_backup", 8'h01, irq_oe);
    tick(BATT + 5);
    rd("flags_backup", supervisor_pkg::ADDR_FLAGS, 8'h04);
    @(posedge clk_sys_i);
    batt_low <= 1'b0;
    supply_good <= 1'b1;
    n = 0;
    while (pin(fa, fa_oe) !== 1'b1 && n < 5) begin
      tick(1);
      n++;
    end
    while (pin(fa, fa_oe) === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk_in("fail_forced_high", n, REC_L - 2, REC_L + 8);
    @(posedge clk_sys_i);
    sense_a <= 1'b0;
  endtask

  task automatic t_irq_pin;
    rd("ctrl_after_loss", supervisor_pkg::ADDR_CTRL, 8'h20);
    wr(supervisor_pkg::ADDR_CTRL, 8'hA0);
    irq_is("irq_out_high", 1'b0);
    wr(supervisor_pkg::ADDR_CTRL, 8'hA1);
    irq_is("irq_of_on", 1'b1);
    rd("flags_of", supervisor_pkg::ADDR_FLAGS, 8'h04);
    irq_is("irq_after_read", 1'b1);
    wr(supervisor_pkg::ADDR_FLAGS, 8'h00);
    irq_is("irq_of_clear", 1'b0);
    rd("flags_clear", supervisor_pkg::ADDR_FLAGS, 8'h00);
    @(posedge clk_sys_i);
    osc_run <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    osc_run <= 1'b1;
    irq_is("irq_osc_stop", 1'b1);
    rd("flags_osc_stop", supervisor_pkg::ADDR_FLAGS, 8'h04);
    wr(supervisor_pkg::ADDR_CTRL, 8'hA0);
    irq_is("irq_enable_off", 1'b0);
    wr(supervisor_pkg::ADDR_CTRL, 8'hA1);
    hit(1'b0, REC_L);
    irq_is("irq_after_reset", 1'b0);
    wr(supervisor_pkg::ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_battery;
    @(posedge clk_sys_i);
    batt_low <= 1'b1;
    tick(BATT + 5);
    rd("batt_low_set", supervisor_pkg::ADDR_FLAGS, 8'h10);
    @(posedge clk_sys_i);
    batt_low <= 1'b0;
    tick(2);
    rd("batt_low_held", supervisor_pkg::ADDR_FLAGS, 8'h10);
    tick(BATT + 5);
    rd("batt_low_gone", supervisor_pkg::ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_serial_century;
    int i;
    wr(supervisor_pkg::ADDR_SERIAL, 8'hFF);
    for (i = 0; i < 8; i++) begin
      wr(supervisor_pkg::ADDR_SERIAL_SEL, 8'(i));
      rd("serial", supervisor_pkg::ADDR_SERIAL, supervisor_pkg::SERIAL_DEFAULT[8*i +: 8]);
    end
    rd("unmapped", 4'h7, 8'h00);
    for (i = 1; i <= 4; i++) begin
      @(posedge clk_sys_i);
      roll <= 1'b1;
      @(posedge clk_sys_i);
      roll <= 1'b0;
      rd("century", supervisor_pkg::ADDR_CENTURY, 8'(i % 4));
      chk("leap", 8'(i % 4 == 0), leap);
    end
  endtask

  // ------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------------
  task automatic stop_test;
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // The whole run needs under a thousand cycles; a hang stops here.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    int n;
    reset_i = 1'b1;
    supply_good = 1'b1;
    {sense_a, sense_b, batt_low, roll, wr_s, rd_s, start_a, start_b} = 8'h00;
    osc_run = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    width = 8'h00;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk_in("power_on_release", n, REC_L, REC_L + 6);
    rd("ctrl_default", supervisor_pkg::ADDR_CTRL, 8'hA0);
    rd("flags_default", supervisor_pkg::ADDR_FLAGS, 8'h04);
    rd("clock_default", supervisor_pkg::ADDR_CLOCK, 8'h00);
    t_reset_in();
    t_fail_out();
    t_irq_pin();
    t_battery();
    t_serial_century();
    stop_test();
  end
endmodule
